// ### core/energy_dsp_pkg.sv
// Constants, register map and carrier types of the energy back end
package energy_dsp_pkg;
	// Bus geometry: word index lives in adr[17:2]
	localparam int ADR_W = 18;
	localparam int IDX_W = 16;
	// Register word indices, byte address is four times the index
	localparam logic [15:0] IDX_CTRL = 16'h9320;
	localparam logic [15:0] IDX_STATUS = 16'h9321;
	localparam logic [15:0] IDX_NSAMP = 16'h9322;
	localparam logic [15:0] IDX_ENERGY = 16'h9323;
	localparam logic [15:0] IDX_GAIN_V = 16'h9324;
	localparam logic [15:0] IDX_GAIN_I1 = 16'h9325;
	localparam logic [15:0] IDX_GAIN_I2 = 16'h9326;
	localparam logic [15:0] IDX_PLEV1 = 16'h9327;
	localparam logic [15:0] IDX_PLEV2 = 16'h9328;
	localparam logic [15:0] IDX_CREEP = 16'h9329;
	localparam logic [15:0] IDX_SQ_V = 16'h932A;
	localparam logic [15:0] IDX_SQ_I1 = 16'h932B;
	localparam logic [15:0] IDX_SQ_I2 = 16'h932C;
	localparam logic [15:0] IDX_MCONST = 16'h9330;
	localparam logic [15:0] IDX_VFIX_A = 16'h9334;
	localparam logic [15:0] IDX_VFIX_B = 16'h9335;
	// Status bit positions
	localparam int ST_ACK = 0;
	localparam int ST_DAI = 1;
	localparam int ST_DIR = 4;
	// Reset values
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam logic [15:0] NSAMP_RST = 16'h0DA8;
	localparam logic [15:0] GAIN_RST = 16'h8000;
	localparam logic [15:0] VFIX_RST = 16'h0B3D;
	localparam logic [23:0] PLEV_RST = 24'h08B646;
	localparam logic [15:0] CREEP_RST = 16'h0010;
	localparam logic [3:0] MCONST_RST = 4'h0;
	localparam logic [3:0] MCONST_MAX = 4'hB;
	// Datapath widths and filter shifts
	localparam int DW = 18;
	localparam int PW = 36;
	localparam int EQ_SHIFT = 3;
	localparam int HP_SHIFT = 7;
	localparam int LP_SHIFT = 5;
	localparam int GAIN_FRAC = 15;
	localparam int PLEV_SCALE = 12;
	localparam int CREEP_POS = 20;
	// Energy bookkeeping: fast pulses per kWh and Ws per pulse numerator
	localparam int FAST_RATE_KWH = 204800;
	localparam int PULSE_WS_NUM = 1000 * 3600;
	// LED pulse width
	localparam int CLK_NS = 4;
	localparam int LED_ON_NS = 4000;
	localparam int LED_ON_CYC = (LED_ON_NS + CLK_NS - 1) / CLK_NS;
	// Control word, equ_bypass in bit 0
	typedef struct packed {
		logic led_pol;
		logic current_sel;
		logic power_real;
		logic volt_src_fixed;
		logic dc_block_bypass;
		logic equ_bypass;
	} ctrl_type;
	// Captured sum-of-squares results
	typedef struct packed {
		logic [31:0] volt;
		logic [31:0] cur1;
		logic [31:0] cur2;
	} squares_type;
endpackage

// ### core/energy_dsp_backend.sv
// Energy metering back end: filters, calibration, power, pulses, accumulator
//
// Design decision made here: the Wishbone slave port.
module energy_dsp_backend (
	input logic clk_i,
	input logic rst_i,
	input logic ce_i,
	input logic cyc_i,
	input logic stb_i,
	input logic we_i,
	input logic [17:0] adr_i,
	input logic [3:0] sel_i,
	input logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input logic sample_i,
	input logic [15:0] voltage_i,
	input logic [15:0] current1_i,
	input logic [15:0] current2_i,
	output logic led_o,
	output logic energy_irq_o
);
	localparam int DW = energy_dsp_pkg::DW;
	localparam int PW = energy_dsp_pkg::PW;

	// Word index match
	function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
		return a[17:2] == idx;
	endfunction

	// Byte-lane merge of a write into an old value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				r[8*b +: 8] = d[8*b +: 8];
		end
		return r;
	endfunction

	// Droop compensation, one sample late so the kernel stays causal
	function automatic logic signed [17:0] eq_step(input logic signed [17:0] x,
		input logic signed [17:0] x1, input logic signed [17:0] x2);
		logic signed [19:0] d;
		d = (20'(x1) <<< 1) - 20'(x) - 20'(x2);
		return x1 + 18'(d >>> energy_dsp_pkg::EQ_SHIFT);
	endfunction

	// Gain scale, wraps if gain near two drives full scale
	function automatic logic signed [17:0] cal_step(input logic signed [17:0] x,
		input logic [15:0] g);
		logic signed [34:0] p;
		p = x * $signed({1'b0, g});
		return p[32:15];
	endfunction

	energy_dsp_pkg::ctrl_type ctrl_r;
	energy_dsp_pkg::squares_type sq_r;
	logic ack_r, dai_r, flag_ack_r, dir_r, led_r;
	logic [31:0] dat_r, energy_r, pulse_cnt_r;
	logic [15:0] nsamp_r, win_cnt_r, creep_r;
	logic [15:0] gain_r [3];
	logic [7:0] vfix_a_r, vfix_b_r;
	logic [23:0] plev1_r, plev2_r;
	logic [3:0] mconst_r;
	logic [47:0] sum_r [3];
	logic signed [DW-1:0] x1_r [3];
	logic signed [DW-1:0] x2_r [3];
	logic signed [DW+6:0] dc_r [3];
	logic signed [PW+4:0] lpf_r;
	logic [PW:0] fast_acc_r;
	logic [10:0] led_cnt_r;
	logic [9:0] led_on_r;

	// Bus request decode; one cycle of wait then ack
	wire req = cyc_i & stb_i & ~ack_r;
	wire wr = req & we_i;
	wire [31:0] rd_word =
		hit(adr_i, energy_dsp_pkg::IDX_CTRL) ? {26'h0, ctrl_r} :
		hit(adr_i, energy_dsp_pkg::IDX_STATUS) ? {27'h0, dir_r, 2'b00, dai_r, flag_ack_r} :
		hit(adr_i, energy_dsp_pkg::IDX_NSAMP) ? {16'h0, nsamp_r} :
		hit(adr_i, energy_dsp_pkg::IDX_ENERGY) ? energy_r :
		hit(adr_i, energy_dsp_pkg::IDX_GAIN_V) ? {16'h0, gain_r[0]} :
		hit(adr_i, energy_dsp_pkg::IDX_GAIN_I1) ? {16'h0, gain_r[1]} :
		hit(adr_i, energy_dsp_pkg::IDX_GAIN_I2) ? {16'h0, gain_r[2]} :
		hit(adr_i, energy_dsp_pkg::IDX_PLEV1) ? {8'h0, plev1_r} :
		hit(adr_i, energy_dsp_pkg::IDX_PLEV2) ? {8'h0, plev2_r} :
		hit(adr_i, energy_dsp_pkg::IDX_CREEP) ? {16'h0, creep_r} :
		hit(adr_i, energy_dsp_pkg::IDX_SQ_V) ? sq_r.volt :
		hit(adr_i, energy_dsp_pkg::IDX_SQ_I1) ? sq_r.cur1 :
		hit(adr_i, energy_dsp_pkg::IDX_SQ_I2) ? sq_r.cur2 :
		hit(adr_i, energy_dsp_pkg::IDX_MCONST) ? {28'h0, mconst_r} :
		hit(adr_i, energy_dsp_pkg::IDX_VFIX_A) ? {24'h0, vfix_a_r} :
		hit(adr_i, energy_dsp_pkg::IDX_VFIX_B) ? {24'h0, vfix_b_r} : 32'h0;
	wire [31:0] st_wr = merge(32'h0, dat_i, sel_i);
	wire st_hit = wr & hit(adr_i, energy_dsp_pkg::IDX_STATUS);
	wire clr_ack = st_hit & st_wr[energy_dsp_pkg::ST_ACK];
	wire clr_dai = st_hit & st_wr[energy_dsp_pkg::ST_DAI];

	// Sample strobe and window end
	wire smp = ce_i & sample_i;
	wire [16:0] win_next = {1'b0, win_cnt_r} + 17'h1;
	wire win_end = smp & (win_next >= {1'b0, nsamp_r});

	// Per-channel chain: equalizer, DC block, gain
	logic signed [DW-1:0] raw [3];
	logic signed [DW-1:0] eq [3];
	logic signed [DW-1:0] hp [3];
	logic signed [DW-1:0] cal [3];
	logic [PW-1:0] sq [3];
	always_comb
	begin
		raw[0] = DW'($signed(voltage_i));
		raw[1] = DW'($signed(current1_i));
		raw[2] = DW'($signed(current2_i));
		for (int k = 0; k < 3; k++)
		begin
			eq[k] = ctrl_r.equ_bypass ? raw[k] : eq_step(raw[k], x1_r[k], x2_r[k]);
			hp[k] = ctrl_r.dc_block_bypass ? eq[k] :
				eq[k] - DW'(dc_r[k] >>> energy_dsp_pkg::HP_SHIFT);
			cal[k] = cal_step(hp[k], gain_r[k]);
			// Widen before squaring, an 18-bit product would lose the top
			sq[k] = PW'(cal[k]) * PW'(cal[k]);
		end
	end

	// Power product, optional low-pass, magnitude and creep gate
	wire signed [DW-1:0] v_pow = ctrl_r.volt_src_fixed ?
		DW'({vfix_b_r, vfix_a_r}) : cal[0];
	wire signed [DW-1:0] i_pow = ctrl_r.current_sel ? cal[2] : cal[1];
	wire signed [PW-1:0] inst = v_pow * i_pow;
	wire signed [PW-1:0] lpf_out = PW'(lpf_r >>> energy_dsp_pkg::LP_SHIFT);
	wire signed [PW-1:0] p_sel = ctrl_r.power_real ? lpf_out : inst;
	wire dir_now = lpf_out < 0;
	// With the measured voltage, ripple below zero on a forward line counts as nothing
	wire [PW-1:0] p_mag = !p_sel[PW-1] ? p_sel :
		(dir_now | ctrl_r.volt_src_fixed) ? -p_sel : '0;
	wire creep = p_mag[PW-1:energy_dsp_pkg::CREEP_POS] < creep_r;
	wire [PW-1:0] p_add = creep ? '0 : p_mag;
	wire [23:0] plev = ctrl_r.current_sel ? plev2_r : plev1_r;
	wire [PW:0] thr = (PW+1)'(plev) << energy_dsp_pkg::PLEV_SCALE;
	wire [PW:0] acc_sum = fast_acc_r + {1'b0, p_add};
	wire fast = smp & (acc_sum >= thr);
	wire [31:0] win_total = pulse_cnt_r + {31'h0, fast};
	// LED divider: 2^mconst fast pulses per LED pulse, top codes clamp
	wire [3:0] mc = (mconst_r > energy_dsp_pkg::MCONST_MAX) ?
		energy_dsp_pkg::MCONST_MAX : mconst_r;
	wire [10:0] led_div_m1 = 11'((12'h1 << mc) - 12'h1);
	wire led_fire = fast & (led_cnt_r == led_div_m1);

	// Bus ack and read data
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r <= 1'b0;
			dat_r <= 32'h0;
		end
		else if (ce_i)
		begin
			ack_r <= req;
			dat_r <= req ? rd_word : dat_r;
		end
	end
	assign ack_o = ack_r;
	assign dat_o = dat_r;

	// Software-written configuration
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_r <= energy_dsp_pkg::CTRL_RST;
			nsamp_r <= energy_dsp_pkg::NSAMP_RST;
			gain_r <= '{energy_dsp_pkg::GAIN_RST, energy_dsp_pkg::GAIN_RST,
				energy_dsp_pkg::GAIN_RST};
			plev1_r <= energy_dsp_pkg::PLEV_RST;
			plev2_r <= energy_dsp_pkg::PLEV_RST;
			creep_r <= energy_dsp_pkg::CREEP_RST;
			mconst_r <= energy_dsp_pkg::MCONST_RST;
			vfix_a_r <= energy_dsp_pkg::VFIX_RST[7:0];
			vfix_b_r <= energy_dsp_pkg::VFIX_RST[15:8];
		end
		else if (ce_i & wr)
		begin
			if (hit(adr_i, energy_dsp_pkg::IDX_CTRL))
				ctrl_r <= 6'(merge({26'h0, ctrl_r}, dat_i, sel_i));
			else if (hit(adr_i, energy_dsp_pkg::IDX_NSAMP))
				nsamp_r <= 16'(merge({16'h0, nsamp_r}, dat_i, sel_i));
			else if (hit(adr_i, energy_dsp_pkg::IDX_GAIN_V))
				gain_r[0] <= 16'(merge({16'h0, gain_r[0]}, dat_i, sel_i));
			else if (hit(adr_i, energy_dsp_pkg::IDX_GAIN_I1))
				gain_r[1] <= 16'(merge({16'h0, gain_r[1]}, dat_i, sel_i));
			else if (hit(adr_i, energy_dsp_pkg::IDX_GAIN_I2))
				gain_r[2] <= 16'(merge({16'h0, gain_r[2]}, dat_i, sel_i));
			else if (hit(adr_i, energy_dsp_pkg::IDX_PLEV1))
				plev1_r <= 24'(merge({8'h0, plev1_r}, dat_i, sel_i));
			else if (hit(adr_i, energy_dsp_pkg::IDX_PLEV2))
				plev2_r <= 24'(merge({8'h0, plev2_r}, dat_i, sel_i));
			else if (hit(adr_i, energy_dsp_pkg::IDX_CREEP))
				creep_r <= 16'(merge({16'h0, creep_r}, dat_i, sel_i));
			else if (hit(adr_i, energy_dsp_pkg::IDX_MCONST))
				mconst_r <= 4'(merge({28'h0, mconst_r}, dat_i, sel_i));
			else if (hit(adr_i, energy_dsp_pkg::IDX_VFIX_A))
				vfix_a_r <= 8'(merge({24'h0, vfix_a_r}, dat_i, sel_i));
			else if (hit(adr_i, energy_dsp_pkg::IDX_VFIX_B))
				vfix_b_r <= 8'(merge({24'h0, vfix_b_r}, dat_i, sel_i));
		end
	end

	// Filter state, advanced once per sample
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			x1_r <= '{default: '0};
			x2_r <= '{default: '0};
			dc_r <= '{default: '0};
			lpf_r <= '0;
			dir_r <= 1'b0;
		end
		else if (smp)
		begin
			for (int k = 0; k < 3; k++)
			begin
				x1_r[k] <= raw[k];
				x2_r[k] <= x1_r[k];
				dc_r[k] <= dc_r[k] + (DW+7)'(eq[k]) - (dc_r[k] >>> energy_dsp_pkg::HP_SHIFT);
			end
			lpf_r <= lpf_r + (PW+5)'(inst) - (lpf_r >>> energy_dsp_pkg::LP_SHIFT);
			dir_r <= dir_now;
		end
	end

	// Window counting and sum-of-squares capture
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			win_cnt_r <= 16'h0000;
			sum_r <= '{default: '0};
			sq_r <= '0;
		end
		else if (smp)
		begin
			win_cnt_r <= win_end ? 16'h0000 : win_next[15:0];
			for (int k = 0; k < 3; k++)
				sum_r[k] <= win_end ? 48'h0 : sum_r[k] + 48'(sq[k]);
			if (win_end)
				sq_r <= {32'((sum_r[0] + 48'(sq[0])) >> 16),
					32'((sum_r[1] + 48'(sq[1])) >> 16),
					32'((sum_r[2] + 48'(sq[2])) >> 16)};
		end
	end

	// Fast pulse generator and energy accumulator handover
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fast_acc_r <= '0;
			pulse_cnt_r <= 32'h0;
			energy_r <= 32'h0;
			dai_r <= 1'b0;
			flag_ack_r <= 1'b0;
		end
		else if (ce_i)
		begin
			if (smp)
				fast_acc_r <= fast ? acc_sum - thr : acc_sum;
			pulse_cnt_r <= win_end ? 32'h0 : win_total;
			if (win_end)
				energy_r <= flag_ack_r ? energy_r + win_total : win_total;
			// Set beats a clear landing in the same cycle
			dai_r <= win_end | (dai_r & ~clr_dai);
			flag_ack_r <= win_end | (flag_ack_r & ~clr_ack);
		end
	end
	assign energy_irq_o = dai_r;

	// LED pulse divider and stretcher
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			led_cnt_r <= 11'h000;
			led_on_r <= 10'h000;
			led_r <= 1'b0;
		end
		else if (ce_i)
		begin
			if (fast)
				led_cnt_r <= led_fire ? 11'h000 : led_cnt_r + 11'h001;
			if (led_fire)
				led_on_r <= 10'(energy_dsp_pkg::LED_ON_CYC);
			else if (led_on_r != 10'h000)
				led_on_r <= led_on_r - 10'h001;
			led_r <= ctrl_r.led_pol ^ (led_fire | (led_on_r > 10'h001));
		end
	end
	assign led_o = led_r;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Checks next to the logic they guard
	irq_rise_a: assert property ($rose(energy_irq_o) |-> $past(win_end))
		else $error("interrupt rose without a window end");
	irq_hold_a: assert property (energy_irq_o && !(ce_i && clr_dai) |=> energy_irq_o)
		else $error("interrupt dropped while data-available set");
	window_flags_a: assert property (win_end |=> dai_r && flag_ack_r && energy_irq_o)
		else $error("window end did not set flags");
	carry_over_a: assert property (win_end && flag_ack_r |=>
		energy_r == $past(energy_r) + $past(win_total))
		else $error("untaken energy not carried");
	fresh_window_a: assert property (win_end && !flag_ack_r |=> energy_r == $past(win_total))
		else $error("window energy not loaded");
	creep_hold_a: assert property (smp && creep && !fast |=>
		fast_acc_r == $past(fast_acc_r))
		else $error("creep changed the accumulator");
	unity_gain_a: assert property (gain_r[1] == 16'h8000 |-> cal[1] == hp[1])
		else $error("unity gain altered the channel");
	hp_bypass_a: assert property (ctrl_r.dc_block_bypass |-> hp[0] == eq[0] && hp[2] == eq[2])
		else $error("high-pass bypass not honoured");
	fixed_volt_a: assert property (ctrl_r.volt_src_fixed |->
		v_pow == DW'({vfix_b_r, vfix_a_r}))
		else $error("fixed voltage not selected");
	dir_read_a: assert property (req && !we_i && hit(adr_i, energy_dsp_pkg::IDX_STATUS) && ce_i
		|=> ack_o && dat_o[energy_dsp_pkg::ST_DIR] == $past(dir_r))
		else $error("direction bit misreported");
	add_positive_a: assert property (smp |-> !p_add[PW-1] || p_add == '0 || !p_sel[PW-1]
		|| dir_now || ctrl_r.volt_src_fixed)
		else $error("negative power added");

	late_ack_c: cover property (win_end && flag_ack_r);
	led_pulse_c: cover property (led_fire);
	clear_race_c: cover property (win_end && clr_dai);
	creep_c: cover property (smp && creep);
endmodule

// ### bench/sample_source.sv
// Front-end model that hands decimated samples to the back end in bursts
module sample_source (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [15:0] count_i,
	input wire logic [15:0] volt_i,
	input wire logic [15:0] cur1_i,
	input wire logic [15:0] cur2_i,
	output logic sample_o,
	output logic [15:0] voltage_o,
	output logic [15:0] current1_o,
	output logic [15:0] current2_o,
	output logic busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] left_r;
	logic [1:0] div_r;
	// One sample strobe every fourth cycle while a burst is pending
	assign sample_o = (left_r != 16'h0000) && (div_r == 2'h3);
	assign busy_o = left_r != 16'h0000;
	// Inverted data between strobes, so a capture off the strobe is caught
	assign voltage_o = sample_o ? volt_i : ~volt_i;
	assign current1_o = sample_o ? cur1_i : ~cur1_i;
	assign current2_o = sample_o ? cur2_i : ~cur2_i;
	// Burst counter and strobe divider
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			left_r <= 16'h0000;
			div_r <= 2'h0;
		end
		else
		begin
			div_r <= div_r + 2'h1;
			if (start_i)
				left_r <= count_i;
			else if (sample_o)
				left_r <= left_r - 16'h0001;
		end
	end
endmodule

// ### bench/test_energy_dsp_backend.sv
// Self-checking bench of the energy back end over its register bus
module test_energy_dsp_backend;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [17:0] adr = 18'h00000;
	logic [3:0] sel = 4'hF;
	logic [31:0] dat = 32'h00000000;
	logic start = 1'b0;
	logic [15:0] count = 16'h0000;
	logic [15:0] volt = 16'h0000;
	logic [15:0] cur1 = 16'h0000;
	logic [15:0] cur2 = 16'h0000;
	logic [31:0] q;
	wire logic [31:0] dat_o;
	wire logic ack_o;
	wire logic sample;
	wire logic [15:0] vs;
	wire logic [15:0] c1s;
	wire logic [15:0] c2s;
	wire logic led_o;
	wire logic energy_irq_o;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	localparam logic [15:0] r_idx [9] = '{energy_dsp_pkg::IDX_CTRL, energy_dsp_pkg::IDX_NSAMP,
		energy_dsp_pkg::IDX_GAIN_V, energy_dsp_pkg::IDX_GAIN_I1, energy_dsp_pkg::IDX_GAIN_I2,
		energy_dsp_pkg::IDX_VFIX_A, energy_dsp_pkg::IDX_VFIX_B, energy_dsp_pkg::IDX_CREEP,
		energy_dsp_pkg::IDX_PLEV1};
	localparam logic [31:0] r_val [9] = '{32'h0, 32'h0DA8, 32'h8000, 32'h8000, 32'h8000,
		32'h3D, 32'h0B, 32'h10, 32'h0008B646};

	always #2 clk_i = ~clk_i;

	// Design and the sample source facing it
	energy_dsp_backend u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
		.sample_i(sample), .voltage_i(vs), .current1_i(c1s), .current2_i(c2s), .led_o(led_o),
		.energy_irq_o(energy_irq_o));
	sample_source u_src (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .count_i(count),
		.volt_i(volt), .cur1_i(cur1), .cur2_i(cur2), .sample_o(sample), .voltage_o(vs),
		.current1_o(c1s), .current2_o(c2s), .busy_o());

	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask

	// Classic single cycle; waits for ack without assuming its latency
	task automatic wb(input logic w, input logic [15:0] idx, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		dat <= d;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 20);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 20)
			chk({31'h0, ack_o}, 32'h1);
	endtask

	task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
		wb(1'b0, idx, 32'h0);
		chk(q, exp);
	endtask

	// Energy register, summed over the windows since the last acknowledge, must fall in a range, pipeline slack allowed
	task automatic e_chk(input int lo, input int hi);
		wb(1'b0, energy_dsp_pkg::IDX_ENERGY, 32'h0);
		chk({31'h0, (q >= lo && q <= hi)}, 32'h1);
	endtask

	// Send a burst of samples and wait for the window interrupt
	task automatic burst(input logic [15:0] n);
		int t;
		@(posedge clk_i);
		start <= 1'b1;
		count <= n;
		@(posedge clk_i);
		start <= 1'b0;
		t = 0;
		while (energy_irq_o !== 1'b1 && t < 2000)
		begin
			@(posedge clk_i);
			t++;
		end
		chk({31'h0, energy_irq_o}, 32'h1);
	endtask

	// Hang guard, well above the few thousand cycles the sequence needs
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			num_errors++;
			stop_test();
		end
	end

	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		chk({31'h0, energy_irq_o}, 32'h0);
		for (int k = 0; k < 9; k++)
			rd_chk(r_idx[k], r_val[k]);
		wb(1'b1, energy_dsp_pkg::IDX_VFIX_A, 32'h55);
		rd_chk(energy_dsp_pkg::IDX_VFIX_A, 32'h55);
		wb(1'b1, energy_dsp_pkg::IDX_VFIX_A, 32'h3D);
		wb(1'b1, 16'h0100, 32'h1234);
		rd_chk(16'h0100, 32'h0);
		wb(1'b1, energy_dsp_pkg::IDX_ENERGY, 32'hFFFF);
		rd_chk(energy_dsp_pkg::IDX_ENERGY, 32'h0);
		wb(1'b1, energy_dsp_pkg::IDX_CTRL, 32'h03);
		wb(1'b1, energy_dsp_pkg::IDX_NSAMP, 32'h8);
		// One pulse per 0x1000 by 0x1000 sample product at half current gain, so no residue carries over
		wb(1'b1, energy_dsp_pkg::IDX_PLEV1, 32'h800);
		wb(1'b1, energy_dsp_pkg::IDX_PLEV2, 32'h800);
		// Test power sits below the reset creep floor, so lift the gate
		wb(1'b1, energy_dsp_pkg::IDX_CREEP, 32'h0);
		wb(1'b1, energy_dsp_pkg::IDX_GAIN_I1, 32'h4000);
		wb(1'b1, energy_dsp_pkg::IDX_GAIN_I2, 32'h0);
		volt <= 16'h1000;
		cur1 <= 16'h1000;
		cur2 <= 16'h1000;
		burst(16'h0008);
		chk({31'h0, led_o}, 32'h1);
		wb(1'b0, energy_dsp_pkg::IDX_STATUS, 32'h0);
		chk(q & 32'h13, 32'h03);
		rd_chk(energy_dsp_pkg::IDX_SQ_V, 32'h800);
		rd_chk(energy_dsp_pkg::IDX_SQ_I1, 32'h200);
		rd_chk(energy_dsp_pkg::IDX_SQ_I2, 32'h0);
		e_chk(5, 8);
		chk({31'h0, energy_irq_o}, 32'h1);
		wb(1'b1, energy_dsp_pkg::IDX_STATUS, 32'h2);
		repeat (2) @(posedge clk_i);
		chk({31'h0, energy_irq_o}, 32'h0);
		wb(1'b0, energy_dsp_pkg::IDX_STATUS, 32'h0);
		chk(q & 32'h3, 32'h1);
		burst(16'h0008);
		e_chk(11, 16);
		wb(1'b1, energy_dsp_pkg::IDX_STATUS, 32'h3);
		wb(1'b1, energy_dsp_pkg::IDX_CREEP, 32'hFFFF);
		burst(16'h0008);
		e_chk(0, 0);
		wb(1'b1, energy_dsp_pkg::IDX_STATUS, 32'h3);
		wb(1'b1, energy_dsp_pkg::IDX_CREEP, 32'h0);
		wb(1'b1, energy_dsp_pkg::IDX_CTRL, 32'h07);
		volt <= 16'h0000;
		burst(16'h0008);
		e_chk(5, 8);
		wb(1'b1, energy_dsp_pkg::IDX_STATUS, 32'h3);
		wb(1'b1, energy_dsp_pkg::IDX_CTRL, 32'h03);
		burst(16'h0008);
		e_chk(0, 1);
		wb(1'b1, energy_dsp_pkg::IDX_STATUS, 32'h3);
		volt <= 16'h1000;
		cur1 <= 16'hF000;
		wb(1'b1, energy_dsp_pkg::IDX_NSAMP, 32'h40);
		burst(16'h0040);
		wb(1'b0, energy_dsp_pkg::IDX_STATUS, 32'h0);
		chk(q & 32'h13, 32'h13);
		e_chk(20, 64);
		wb(1'b1, energy_dsp_pkg::IDX_STATUS, 32'h3);
		wb(1'b1, energy_dsp_pkg::IDX_NSAMP, 32'h8);
		// Second current channel needs a live gain to carry power
		wb(1'b1, energy_dsp_pkg::IDX_GAIN_I2, 32'h4000);
		wb(1'b1, energy_dsp_pkg::IDX_PLEV1, 32'hFFFFFF);
		cur1 <= 16'h0000;
		cur2 <= 16'h1000;
		wb(1'b1, energy_dsp_pkg::IDX_CTRL, 32'h13);
		burst(16'h0008);
		e_chk(5, 8);
		wb(1'b1, energy_dsp_pkg::IDX_STATUS, 32'h3);
		wb(1'b1, energy_dsp_pkg::IDX_CTRL, 32'h1B);
		burst(16'h0008);
		e_chk(1, 8);
		wb(1'b1, energy_dsp_pkg::IDX_STATUS, 32'h3);
		repeat (1100) @(posedge clk_i);
		chk({31'h0, led_o}, 32'h0);
		wb(1'b1, energy_dsp_pkg::IDX_CTRL, 32'h33);
		repeat (2) @(posedge clk_i);
		chk({31'h0, led_o}, 32'h1);
		stop_test();
	end
endmodule
